// file: verilog/epc_top.v
// Enhanced compare/PWM unit with APB register slave
//
// Decided for this implementation: the APB interface to the registers and the address map.
`include "epc_map.vh"
module epc_top #(
   parameter UNIT_INDEX = 2
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire pready_o,
   output reg [31:0] prdata_o,
   output reg pslverr_o,
   input wire adc_enable_i,
   input wire basic_out_i,
   output reg out_a_o,
   output reg out_b_o,
   output reg out_c_o,
   output reg out_d_o,
   output reg shared_pin_o,
   output reg trigger_o,
   output reg adc_start_o,
   output reg update_o
);
   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function mapped;
      input [7:0] a;
      begin
         case (a)
            `EPC_OFF_CTRL, `EPC_OFF_DUTYL, `EPC_OFF_DUTYA, `EPC_OFF_PERIOD, `EPC_OFF_PTMR,
            `EPC_OFF_DEL, `EPC_OFF_TCTRL, `EPC_OFF_CMP, `EPC_OFF_FLAGS, `EPC_OFF_TMR16: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   endfunction

   reg [7:0] ctrl_q;
   reg [7:0] dutyl_q;
   reg [7:0] period_q;
   reg [7:0] del_q;
   reg [10:0] tctrl_q;
   reg [15:0] cmp_q;
   reg [2:0] flags_q;
   reg [15:0] t1_q;
   reg [15:0] t3_q;
   reg [31:0] rd_d;

   wire wr = psel_i & penable_i & pwrite_i;
   wire setup = psel_i & ~penable_i;
   assign pready_o = 1'b1;

   function wr_hit;
      input [7:0] a;
      input [7:0] off;
      begin
         wr_hit = (a == off);
      end
   endfunction

   // ----------------------------------------
   // Time base
   // ----------------------------------------
   wire cy;
   wire tick;
   wire [1:0] sub;
   epc_prescale u_presc (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .presc_i(tctrl_q[`EPC_TC_PRESC]),
      .cy_o(cy),
      .tick_o(tick),
      .sub_o(sub)
   );

   reg [7:0] per_act_q;
   wire [15:0] ptmr;
   wire [1:0] pwrap;
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_ptmr
         reg [7:0] t_q;
         // Equal to period then next step clears, so period lasts register+1 counts
         assign pwrap[gi] = tctrl_q[`EPC_TC_PON] & tick & (t_q == per_act_q);
         always @(posedge clk_sys_i) begin
            if (rst_i) begin
               t_q <= 8'h00;
            end else if (pwrap[gi]) begin
               t_q <= 8'h00;
            end else if (tctrl_q[`EPC_TC_PON] & tick) begin
               t_q <= t_q + 8'h01;
            end
         end
         assign ptmr[gi*8 +: 8] = t_q;
      end
   endgenerate

   wire tb_sel = tctrl_q[`EPC_TC_TBSEL];
   wire [7:0] tmr = tb_sel ? ptmr[15:8] : ptmr[7:0];
   wire bnd = tb_sel ? pwrap[1] : pwrap[0];

   // Postscaler sees the boundary but never feeds the PWM path
   reg [3:0] post_q;
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         post_q <= 4'h0;
         update_o <= 1'b0;
      end else begin
         update_o <= 1'b0;
         if (bnd) begin
            if (post_q == tctrl_q[`EPC_TC_POST]) begin
               post_q <= 4'h0;
               update_o <= 1'b1;
            end else begin
               post_q <= post_q + 4'h1;
            end
         end
      end
   end

   // ----------------------------------------
   // PWM core
   // ----------------------------------------
   wire [3:0] mode = ctrl_q[`EPC_CTRL_MODE];
   wire pwm_mode = (mode[3:2] == `EPC_PWM_TAG);
   wire [9:0] duty_buf = {dutyl_q, ctrl_q[`EPC_CTRL_DLSB]};
   reg [9:0] duty_act_q;
   reg [1:0] cfg_act_q;
   reg [1:0] pol_act_q;
   reg [6:0] del_act_q;
   reg run_q;
   reg pwm_q;
   // Never matches when duty exceeds the extended period count
   wire duty_hit = run_q & ({tmr, sub} == duty_act_q);
   wire pwm_lvl = pwm_q & ~duty_hit;

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         run_q <= 1'b0;
         pwm_q <= 1'b0;
         duty_act_q <= 10'h000;
         cfg_act_q <= `EPC_CFG_SINGLE;
         pol_act_q <= 2'h0;
         per_act_q <= `EPC_RST_PERIOD;
         del_act_q <= 7'h00;
      end else begin
         if (bnd) begin
            duty_act_q <= duty_buf;
            cfg_act_q <= ctrl_q[`EPC_CTRL_CFG];
            pol_act_q <= mode[1:0];
            per_act_q <= period_q;
         end
         if (bnd | duty_hit) begin
            del_act_q <= del_q[`EPC_DEL_CNT];
         end
         if (!pwm_mode) begin
            run_q <= 1'b0;
         end else if (bnd) begin
            run_q <= 1'b1;
         end
         if (!pwm_mode) begin
            pwm_q <= 1'b0;
         end else if (bnd) begin
            pwm_q <= (duty_buf != 10'h000);
         end else if (duty_hit) begin
            pwm_q <= 1'b0;
         end
      end
   end

   wire db_a;
   wire db_b;
   epc_deadband u_db_a (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .cy_i(cy),
      .level_i(pwm_lvl),
      .delay_i(del_act_q),
      .level_o(db_a)
   );
   epc_deadband u_db_b (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .cy_i(cy),
      .level_i(run_q & ~pwm_lvl),
      .delay_i(del_act_q),
      .level_o(db_b)
   );

   reg act_a;
   reg act_b;
   reg act_c;
   reg act_d;
   always @* begin
      act_a = 1'b0;
      act_b = 1'b0;
      act_c = 1'b0;
      act_d = 1'b0;
      if (run_q) begin
         case (cfg_act_q)
            `EPC_CFG_SINGLE: act_a = pwm_lvl;
            `EPC_CFG_HALF: begin
               act_a = db_a;
               act_b = db_b;
            end
            `EPC_CFG_FWD: begin
               act_a = 1'b1;
               act_d = pwm_lvl;
            end
            `EPC_CFG_REV: begin
               act_c = 1'b1;
               act_b = pwm_lvl;
            end
            default: act_a = 1'b0;
         endcase
      end
   end

   // Polarity bit 1 inverts A/C, bit 0 inverts B/D; idle pins sit low, or high in PWM mode where their polarity bit inverts them
   wire inv_ac = pwm_mode & pol_act_q[1];
   wire inv_bd = pwm_mode & pol_act_q[0];
   wire quad = pwm_mode & cfg_act_q[0];
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         out_a_o <= 1'b0;
         out_b_o <= 1'b0;
         out_c_o <= 1'b0;
         out_d_o <= 1'b0;
         shared_pin_o <= 1'b0;
      end else begin
         out_a_o <= act_a ^ inv_ac;
         out_b_o <= act_b ^ inv_bd;
         out_c_o <= act_c ^ inv_ac;
         out_d_o <= act_d ^ inv_bd;
         shared_pin_o <= quad ? (act_d ^ inv_bd) : basic_out_i;
      end
   end

   // ----------------------------------------
   // Compare and special event trigger
   // ----------------------------------------
   wire has_trig = (UNIT_INDEX == 1) || (UNIT_INDEX == 2);
   wire tr_sel = tctrl_q[`EPC_TC_TRSEL];
   wire [15:0] t16 = tr_sel ? t3_q : t1_q;
   wire cmp_mode = (mode == `EPC_MODE_CMP_SWI) | (mode == `EPC_MODE_CMP_TRIG);
   reg match_d_q;
   wire match = cmp_mode & (t16 == cmp_q);
   wire match_ev = match & ~match_d_q;
   // Units without a trigger fall back to plain compare flag
   wire trig = match_ev & (mode == `EPC_MODE_CMP_TRIG) & has_trig;
   wire t1_ov = tctrl_q[`EPC_TC_T1ON] & cy & (t1_q == 16'hffff);
   wire t3_ov = tctrl_q[`EPC_TC_T3ON] & cy & (t3_q == 16'hffff);
   wire t1_rst = trig & ~tr_sel;
   wire t3_rst = trig & tr_sel;

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         t1_q <= 16'h0000;
         t3_q <= 16'h0000;
         match_d_q <= 1'b0;
         trigger_o <= 1'b0;
         adc_start_o <= 1'b0;
      end else begin
         match_d_q <= match;
         trigger_o <= trig;
         adc_start_o <= trig & (UNIT_INDEX == 2) & adc_enable_i;
         if (t1_rst) begin
            t1_q <= 16'h0000;
         end else if (tctrl_q[`EPC_TC_T1ON] & cy) begin
            t1_q <= t1_q + 16'h0001;
         end
         if (t3_rst) begin
            t3_q <= 16'h0000;
         end else if (tctrl_q[`EPC_TC_T3ON] & cy) begin
            t3_q <= t3_q + 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   wire [2:0] fl_set = {t3_ov & ~t3_rst, t1_ov & ~t1_rst, match_ev};
   wire [2:0] fl_clr = (wr & wr_hit(paddr_i, `EPC_OFF_FLAGS)) ? pwdata_i[2:0] : 3'h0;

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         ctrl_q <= `EPC_RST_CTRL;
         dutyl_q <= 8'h00;
         period_q <= `EPC_RST_PERIOD;
         del_q <= `EPC_RST_DEL;
         tctrl_q <= `EPC_RST_TCTRL;
         cmp_q <= 16'h0000;
         flags_q <= 3'h0;
      end else begin
         // Set wins over a same-cycle clear
         flags_q <= (flags_q & ~fl_clr) | fl_set;
         if (wr) begin
            if (wr_hit(paddr_i, `EPC_OFF_CTRL)) begin
               ctrl_q <= pwdata_i[7:0];
            end
            if (wr_hit(paddr_i, `EPC_OFF_DUTYL)) begin
               dutyl_q <= pwdata_i[7:0];
            end
            if (wr_hit(paddr_i, `EPC_OFF_PERIOD)) begin
               period_q <= pwdata_i[7:0];
            end
            if (wr_hit(paddr_i, `EPC_OFF_DEL)) begin
               del_q <= pwdata_i[7:0];
            end
            if (wr_hit(paddr_i, `EPC_OFF_TCTRL)) begin
               tctrl_q <= pwdata_i[10:0];
            end
            if (wr_hit(paddr_i, `EPC_OFF_CMP)) begin
               cmp_q <= pwdata_i[15:0];
            end
         end
      end
   end

   always @* begin
      case (paddr_i)
         `EPC_OFF_CTRL: rd_d = {24'h000000, ctrl_q};
         `EPC_OFF_DUTYL: rd_d = {24'h000000, dutyl_q};
         `EPC_OFF_DUTYA: rd_d = {22'h000000, duty_act_q};
         `EPC_OFF_PERIOD: rd_d = {24'h000000, period_q};
         `EPC_OFF_PTMR: rd_d = {16'h0000, ptmr};
         `EPC_OFF_DEL: rd_d = {24'h000000, del_q};
         `EPC_OFF_TCTRL: rd_d = {21'h000000, tctrl_q};
         `EPC_OFF_CMP: rd_d = {16'h0000, cmp_q};
         `EPC_OFF_FLAGS: rd_d = {29'h00000000, flags_q};
         `EPC_OFF_TMR16: rd_d = {t3_q, t1_q};
         default: rd_d = 32'h00000000;
      endcase
   end

   // Read data captured in setup so the access phase finishes at once
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         prdata_o <= 32'h00000000;
         pslverr_o <= 1'b0;
      end else if (setup) begin
         prdata_o <= pwrite_i ? 32'h00000000 : rd_d;
         pslverr_o <= ~mapped(paddr_i);
      end
   end
endmodule // epc_top

// file: verilog/epc_map.vh
// Register offsets, field positions, reset values and mode codes of the PWM/compare unit
`ifndef EPC_MAP_VH
`define EPC_MAP_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EPC_OFF_CTRL 8'h00
`define EPC_OFF_DUTYL 8'h04
`define EPC_OFF_DUTYA 8'h08
`define EPC_OFF_PERIOD 8'h0c
`define EPC_OFF_PTMR 8'h10
`define EPC_OFF_DEL 8'h14
`define EPC_OFF_TCTRL 8'h18
`define EPC_OFF_CMP 8'h1c
`define EPC_OFF_FLAGS 8'h20
`define EPC_OFF_TMR16 8'h24
// ----------------------------------------
// Field positions
// ----------------------------------------
`define EPC_CTRL_CFG 7:6
`define EPC_CTRL_DLSB 5:4
`define EPC_CTRL_MODE 3:0
`define EPC_DEL_CNT 6:0
`define EPC_TC_TBSEL 0
`define EPC_TC_PRESC 2:1
`define EPC_TC_POST 6:3
`define EPC_TC_PON 7
`define EPC_TC_TRSEL 8
`define EPC_TC_T1ON 9
`define EPC_TC_T3ON 10
`define EPC_FL_CMP 0
`define EPC_FL_T1OV 1
`define EPC_FL_T3OV 2
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define EPC_RST_CTRL 8'h00
`define EPC_RST_DEL 8'h00
`define EPC_RST_TCTRL 11'h000
`define EPC_RST_PERIOD 8'h00
`define EPC_MODE_CMP_SWI 4'ha
`define EPC_MODE_CMP_TRIG 4'hb
`define EPC_PWM_TAG 2'h3
`define EPC_CFG_SINGLE 2'h0
`define EPC_CFG_FWD 2'h1
`define EPC_CFG_HALF 2'h2
`define EPC_CFG_REV 2'h3
`define EPC_PRESC_1 2'h0
`define EPC_PRESC_4 2'h1
`define EPC_TOSC_PER_CY 2'h3
`endif

// file: verilog/epc_prescale.v
// Instruction-cycle divider and 1/4/16 period timer prescaler with 2-bit sub-count
`include "epc_map.vh"
module epc_prescale (
   input wire clk_sys_i,
   input wire rst_i,
   input wire [1:0] presc_i,
   output wire cy_o,
   output wire tick_o,
   output reg [1:0] sub_o
);
   reg [1:0] q_q;
   reg [3:0] pc_q;
   assign cy_o = (q_q == `EPC_TOSC_PER_CY);
   // Timer steps once per instruction cycle times prescale
   assign tick_o = cy_o & ((presc_i == `EPC_PRESC_1) ? 1'b1 :
                           (presc_i == `EPC_PRESC_4) ? (pc_q[1:0] == 2'h3) : (pc_q == 4'hf));
   always @* begin
      // Quarter-cycle phase or prescaler top bits extend the timer
      case (presc_i)
         `EPC_PRESC_1: sub_o = q_q;
         `EPC_PRESC_4: sub_o = pc_q[1:0];
         default: sub_o = pc_q[3:2];
      endcase
   end
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         q_q <= 2'h0;
         pc_q <= 4'h0;
      end else begin
         q_q <= q_q + 2'h1;
         if (cy_o) begin
            pc_q <= pc_q + 4'h1;
         end
      end
   end
endmodule // epc_prescale

// file: verilog/epc_deadband.v
// Dead-band delay on the inactive-to-active edge of one output
module epc_deadband (
   input wire clk_sys_i,
   input wire rst_i,
   input wire cy_i,
   input wire level_i,
   input wire [6:0] delay_i,
   output reg level_o
);
   reg [6:0] cnt_q;
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         cnt_q <= 7'h00;
         level_o <= 1'b0;
      end else if (!level_i) begin
         // Falling before the delay expires keeps the output off all cycle
         cnt_q <= 7'h00;
         level_o <= 1'b0;
      end else if (!level_o) begin
         if (cnt_q >= delay_i) begin
            level_o <= 1'b1;
         end else if (cy_i) begin
            cnt_q <= cnt_q + 7'h01;
         end
      end
   end
endmodule // epc_deadband

// file: sim/epc_properties.sv
// Concurrent checks on the outputs of the PWM/compare unit
`include "epc_map.vh"
module epc_properties #(
   parameter UNIT_INDEX = 2
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire adc_enable_i,
   input wire basic_out_i,
   input wire out_a_o,
   input wire out_b_o,
   input wire out_c_o,
   input wire out_d_o,
   input wire shared_pin_o,
   input wire trigger_o,
   input wire adc_start_o,
   input wire update_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] ctrl_q;
   logic pol_ok;
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         ctrl_q <= 8'h00;
      end else if (psel_i && penable_i && pwrite_i && paddr_i == `EPC_OFF_CTRL) begin
         ctrl_q <= pwdata_i[7:0];
      end
   end
   // Pattern checks hold only for active-high outputs
   assign pol_ok = (ctrl_q[1:0] == 2'h0);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   sequence s_one_pulse;
      trigger_o ##1 !trigger_o;
   endsequence
   sequence s_idle;
      !out_a_o && !out_b_o && !out_c_o && !out_d_o && !trigger_o && !adc_start_o;
   endsequence
   chk_trig_pulse: assert property ($rose(trigger_o) |-> s_one_pulse)
      else $error("trigger pulse not single cycle");
   chk_adc_with_trig: assert property (adc_start_o |-> trigger_o && UNIT_INDEX == 2)
      else $error("conversion start without trigger");
   chk_adc_follows: assert property (trigger_o && adc_enable_i && $past(adc_enable_i) && $past(adc_enable_i, 2) && UNIT_INDEX == 2 |-> adc_start_o)
      else $error("conversion start missing");
   chk_no_trig_hi: assert property (UNIT_INDEX > 2 |-> !trigger_o)
      else $error("trigger on unit without trigger");
   chk_reset_idle: assert property (@(posedge clk_sys_i) disable iff (1'b0) rst_i |=> s_idle)
      else $error("outputs active after reset");
   chk_half_apart: assert property (pol_ok && ctrl_q[7:6] == 2'h2 |-> !(out_a_o && out_b_o))
      else $error("half bridge outputs overlap");
   chk_fwd_pattern: assert property (pol_ok && out_d_o |-> out_a_o && !out_b_o && !out_c_o)
      else $error("forward pattern wrong");
   chk_rev_pattern: assert property (pol_ok && out_c_o |-> !out_a_o && !out_d_o)
      else $error("reverse pattern wrong");
   chk_shared_pin: assert property (shared_pin_o != $past(basic_out_i) |-> shared_pin_o == out_d_o)
      else $error("shared pin source wrong");
   chk_update_pulse: assert property (update_o |=> !update_o)
      else $error("update pulse too long");
endmodule // epc_properties

bind epc_top epc_properties #(.UNIT_INDEX(UNIT_INDEX)) u_epc_properties (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .adc_enable_i(adc_enable_i), .basic_out_i(basic_out_i), .out_a_o(out_a_o), .out_b_o(out_b_o),
   .out_c_o(out_c_o), .out_d_o(out_d_o), .shared_pin_o(shared_pin_o), .trigger_o(trigger_o),
   .adc_start_o(adc_start_o), .update_o(update_o));

// file: sim/epc_bridge_model.sv
// Power stage model: counts cycles where one leg would shoot through
module epc_bridge_model (
   input wire clk_sys_i,
   input wire hi_a_i,
   input wire lo_b_i,
   output logic [15:0] short_cnt_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial short_cnt_o = 16'h0000;
   // High and low switch of one leg on together shorts the supply
   always @(posedge clk_sys_i) begin
      if (hi_a_i && lo_b_i) begin
         short_cnt_o <= short_cnt_o + 16'h0001;
      end
   end
endmodule // epc_bridge_model

// file: sim/tb.sv
// Self-checking bench of the PWM/compare unit
`include "epc_map.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, adc_enable_i = 1, basic_out_i = 0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, rd;
   logic slv;
   wire pready_o, pslverr_o, out_a_o, out_b_o, out_c_o, out_d_o, shared_pin_o, trigger_o, adc_start_o, update_o;
   wire [31:0] prdata_o;
   wire [15:0] short_cnt;
   int err_count = 0, compares = 0, cycles = 0, na, nb, nc, nd, nup, nadc;
   epc_top #(.UNIT_INDEX(2)) u_epc_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
      .prdata_o(prdata_o), .pslverr_o(pslverr_o), .adc_enable_i(adc_enable_i), .basic_out_i(basic_out_i),
      .out_a_o(out_a_o), .out_b_o(out_b_o), .out_c_o(out_c_o), .out_d_o(out_d_o), .shared_pin_o(shared_pin_o),
      .trigger_o(trigger_o), .adc_start_o(adc_start_o), .update_o(update_o));
   epc_bridge_model u_epc_bridge_model (.clk_sys_i(clk_sys_i), .hi_a_i(out_a_o), .lo_b_i(out_b_o),
      .short_cnt_o(short_cnt));
   // Unit without a trigger sees the same writes, so it matches on the same edge, except for the second timer 1 match: its timer 1 is never cleared
   wire trig_u4;
   epc_top #(.UNIT_INDEX(4)) u_epc_top_u4 (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(),
      .prdata_o(), .pslverr_o(), .adc_enable_i(adc_enable_i), .basic_out_i(basic_out_i), .out_a_o(),
      .out_b_o(), .out_c_o(), .out_d_o(), .shared_pin_o(), .trigger_o(trig_u4), .adc_start_o(), .update_o());
   always #25 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) basic_out_i <= ~basic_out_i;
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         summarize();
      end
   end
   task automatic summarize();
      if (err_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1;
      @(posedge clk_sys_i);
      while (pready_o !== 1'b1) @(posedge clk_sys_i);
      rd = prdata_o; slv = pslverr_o;
      psel_i <= 0; penable_i <= 0;
   endtask
   // Counting high cycles over whole periods avoids edge alignment
   task automatic win(input int n);
      na = 0; nb = 0; nc = 0; nd = 0; nup = 0;
      repeat (n) begin
         @(negedge clk_sys_i);
         na += int'(out_a_o === 1'b1); nb += int'(out_b_o === 1'b1);
         nc += int'(out_c_o === 1'b1); nd += int'(out_d_o === 1'b1); nup += int'(update_o === 1'b1);
      end
   endtask
   task automatic pwm(input logic [31:0] c, dh, tc, input int per, a, b, cc, d);
      apb(1, `EPC_OFF_CTRL, c); apb(1, `EPC_OFF_DUTYL, dh); apb(1, `EPC_OFF_TCTRL, tc);
      win(3 * per); win(2 * per);
      chk("out_a", a, na); chk("out_d", d, nd); chk("out_c", cc, nc);
      if (b >= 0) chk("out_b", b, nb);
   endtask
   task automatic wtrig();
      int k;
      k = 0;
      do begin @(negedge clk_sys_i); k++; end while (trigger_o !== 1'b1 && k < 5000);
      chk("trigger", 1, trigger_o === 1'b1);
      chk("unit4_trigger", 0, trig_u4 === 1'b1);
      nadc = int'(adc_start_o === 1'b1);
   endtask
   task automatic t_reset();
      logic [7:0] offs[4] = '{`EPC_OFF_CTRL, `EPC_OFF_PERIOD, `EPC_OFF_DEL, `EPC_OFF_TCTRL};
      foreach (offs[i]) begin apb(0, offs[i], 0); chk("reg_reset", 0, rd); end
      apb(0, 8'hfc, 0); chk("slverr", 1, slv); chk("unmapped", 0, rd);
   endtask
   task automatic t_single();
      logic [31:0] tcs[4] = '{32'h80, 32'h82, 32'h84, 32'h81};
      int mul[4] = '{1, 4, 16, 1};
      apb(1, `EPC_OFF_PERIOD, 3);
      foreach (tcs[i]) pwm(32'h2c, 1, tcs[i], 16 * mul[i], 12 * mul[i], 0, 0, 0);
      apb(1, `EPC_OFF_DUTYA, 0); apb(0, `EPC_OFF_DUTYA, 0); chk("active_duty", 6, rd);
      pwm(32'h0c, 0, 32'h80, 16, 0, 0, 0, 0);
      pwm(32'h3c, 32'hff, 32'h80, 16, 32, 0, 0, 0);
      pwm(32'h2c, 1, 32'h88, 16, 12, 0, 0, 0); chk("updates", 1, nup);
   endtask
   task automatic t_bridge();
      apb(1, `EPC_OFF_DEL, 1);
      pwm(32'h8c, 2, 32'h80, 16, 8, -1, 0, 0); chk("b_active", 1, nb > 0);
      apb(1, `EPC_OFF_DEL, 3);
      pwm(32'h8c, 2, 32'h80, 16, 0, -1, 0, 0);
      pwm(32'h4c, 2, 32'h80, 16, 32, 0, 0, 16);
      pwm(32'hcc, 2, 32'h80, 16, 0, 16, 32, 0);
      pwm(32'h2e, 1, 32'h80, 16, 20, 0, 32, 0);
      chk("shoot_through", 0, short_cnt);
   endtask
   task automatic t_trig();
      apb(1, `EPC_OFF_TCTRL, 32'h200); apb(1, `EPC_OFF_CMP, 32'h10);
      apb(1, `EPC_OFF_FLAGS, 7); apb(1, `EPC_OFF_CTRL, 32'h0b);
      wtrig(); chk("adc_start", 1, nadc);
      apb(0, `EPC_OFF_FLAGS, 0); chk("flags", 1, rd[1:0]);
      apb(0, `EPC_OFF_TMR16, 0); chk("first_le_cmp", 1, rd[15:0] <= 16'h10);
      @(posedge clk_sys_i) adc_enable_i <= 0;
      wtrig(); chk("adc_start", 0, nadc);
      apb(1, `EPC_OFF_TCTRL, 32'h500);
      wtrig();
      apb(0, `EPC_OFF_TMR16, 0); chk("third_le_cmp", 1, rd[31:16] <= 16'h10);
      apb(0, `EPC_OFF_FLAGS, 0); chk("third_flag", 0, rd[2]);
   endtask
   initial begin
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 0;
      t_reset();
      t_single();
      t_bridge();
      t_trig();
      summarize();
   end
endmodule // tb
